// [verilog/rac_settings_store.sv]
// setting store with serial command interpreter and channel-busy retry
//
// Contract
// - retry delay at 23, 5..255, default 20
// - busy channel waits retry delay before retry
// - destination network at 24, default 0
// - destination network sent only in scheme 2
// - runtime changes touch working copy only
// - scheme 2: network and address 255 broadcast
// - destination address at 25, default 0
// - address used in schemes 1, 2; 255 broadcast
// - own network at 28, 0..254, scheme 2
// - write 0x09 answered 0x49 with status
// - read 0x0A answered 0x4A with bytes
// - scheme 1 accepts own or 255 address
module rac_settings_store #(
	parameter int unsigned MS_CYCLES = rac_pkg::MS_CYCLES // cycles per ms
) (
	input  wire logic                  clk,
	input  wire logic                  arst_n,
	input  wire logic                  host_rx_valid,
	input  wire logic [7:0]            host_rx_data,
	output logic                       host_tx_valid,
	output logic [7:0]                 host_tx_data,
	input  wire logic                  host_tx_ready,
	output rac_pkg::rac_settings_t     settings,
	input  wire logic                  set_runtime_dest_network,
	input  wire logic                  set_runtime_dest_address,
	input  wire logic [7:0]            runtime_value,
	output rac_pkg::rac_addr_t         work_dest,
	input  wire logic [1:0]            addressing_scheme,
	input  wire logic [7:0]            own_node_address_low,
	input  wire logic                  pkt_valid,
	input  wire rac_pkg::rac_addr_t    pkt_dest,
	output logic                       pkt_accept,
	output logic                       pkt_drop,
	output logic                       hdr_dest_network_en,
	output logic                       hdr_dest_address_en,
	output rac_pkg::rac_addr_t         hdr_dest,
	input  wire logic                  tx_req,
	input  wire logic                  chan_busy,
	input  wire logic [7:0]            cca_retry_limit,
	output logic                       tx_go,
	output logic                       tx_abort
);

	// ************************************************************
	// decoding helpers
	// ************************************************************
	// map a memory position to {hit, slot}
	function automatic logic [2:0] slot_of(input logic [7:0] pos);
		unique case (pos)
			rac_pkg::POS_CCA_RETRY_DELAY:    slot_of = {1'b1, rac_pkg::SLOT_CCA};
			rac_pkg::POS_DEST_NETWORK_ID:    slot_of = {1'b1, rac_pkg::SLOT_DNET};
			rac_pkg::POS_DEST_NODE_ADDR_LOW: slot_of = {1'b1, rac_pkg::SLOT_DADR};
			rac_pkg::POS_OWN_NETWORK_ID:     slot_of = {1'b1, rac_pkg::SLOT_ONET};
			default:                         slot_of = 3'h0;
		endcase
	endfunction

	// permitted range of each setting
	function automatic logic value_ok(input logic [1:0] slot,
		input logic [7:0] val);
		unique case (slot)
			rac_pkg::SLOT_CCA:  value_ok = val >= rac_pkg::CCA_RETRY_DELAY_MIN;
			rac_pkg::SLOT_ONET: value_ok = val <= rac_pkg::OWN_NETWORK_ID_MAX;
			default:            value_ok = 1'b1;
		endcase
	endfunction

	// ************************************************************
	// state
	// ************************************************************
	rac_pkg::rac_parse_t    p_st_q;      // frame parser state
	rac_pkg::rac_tx_t       t_st_q;      // answer sender state
	rac_pkg::rac_cca_t      c_st_q;      // clear-channel state
	logic [7:0]             cmd_q;       // command byte of frame
	logic [7:0]             lenf_q;      // length field of frame
	logic [7:0]             pos_q;       // memory position
	logic [7:0]             cnt_q;       // byte count
	logic [7:0]             idx_q;       // data byte index in frame
	logic [7:0]             sum_q;       // running xor of frame
	logic                   bad_q;       // a data byte was refused
	logic [3:0]             hit_q;       // slots staged by this frame
	rac_pkg::rac_settings_t stage_q;     // staged values
	logic                   resp_go_q;   // start an answer
	logic                   resp_wr_q;   // answer is to a write
	logic [7:0]             resp_st_q;   // write status
	logic [7:0]             tx_idx_q;    // data byte index in answer
	logic [7:0]             tx_sum_q;    // running xor of answer
	logic [7:0]             tries_q;     // busy retries so far
	logic [7:0]             delay_q;     // ms left in retry wait
	logic [$clog2(MS_CYCLES+1)-1:0] tick_q; // cycles left in this ms
	logic                   rx_take;     // a command byte is consumed
	logic                   commit;      // staged values are stored
	logic [7:0]             wr_pos;      // position of current data byte
	logic [2:0]             wr_slot;     // its slot
	logic [7:0]             tx_byte;     // byte the sender presents
	logic [7:0]             rd_pos;      // position of answer data byte
	logic [2:0]             rd_slot;     // its slot

	// bytes arriving while an answer is pending or sent are dropped
	assign rx_take = host_rx_valid && !resp_go_q &&
		t_st_q == rac_pkg::T_IDLE;
	assign wr_pos  = pos_q + idx_q;
	assign wr_slot = slot_of(wr_pos);
	assign rd_pos  = pos_q + tx_idx_q;
	assign rd_slot = slot_of(rd_pos);

	// store happens on the closing byte of a clean write frame
	assign commit = rx_take && p_st_q == rac_pkg::P_CSUM &&
		host_rx_data == sum_q && cmd_q == rac_pkg::CMD_WRITE && !bad_q &&
		lenf_q == 8'(cnt_q + rac_pkg::LEN_EXTRA);

	// ************************************************************
	// command frame parser
	// ************************************************************
	// walk the fields and keep the xor of every byte since the start byte
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			p_st_q <= rac_pkg::P_IDLE;
			cmd_q  <= 8'h00;
			lenf_q <= 8'h00;
			pos_q  <= 8'h00;
			cnt_q  <= 8'h00;
			idx_q  <= 8'h00;
			sum_q  <= 8'h00;
		end else if (rx_take) begin
			sum_q <= sum_q ^ host_rx_data;
			unique case (p_st_q)
				rac_pkg::P_IDLE: begin
					// hunt for the start byte
					sum_q <= host_rx_data;
					if (host_rx_data == rac_pkg::START_BYTE) begin
						p_st_q <= rac_pkg::P_CMD;
					end
				end
				rac_pkg::P_CMD: begin
					cmd_q <= host_rx_data;
					// unknown commands fall back to hunting
					if (host_rx_data == rac_pkg::CMD_WRITE ||
						host_rx_data == rac_pkg::CMD_READ) begin
						p_st_q <= rac_pkg::P_LEN;
					end else begin
						p_st_q <= rac_pkg::P_IDLE;
					end
				end
				rac_pkg::P_LEN: begin
					lenf_q <= host_rx_data;
					p_st_q <= rac_pkg::P_POS;
				end
				rac_pkg::P_POS: begin
					pos_q  <= host_rx_data;
					p_st_q <= rac_pkg::P_CNT;
				end
				rac_pkg::P_CNT: begin
					cnt_q <= host_rx_data;
					idx_q <= 8'h00;
					// only writes carry parameter bytes
					if (cmd_q == rac_pkg::CMD_WRITE && host_rx_data != 8'h00) begin
						p_st_q <= rac_pkg::P_DATA;
					end else begin
						p_st_q <= rac_pkg::P_CSUM;
					end
				end
				rac_pkg::P_DATA: begin
					idx_q <= idx_q + 8'h01;
					if (idx_q == cnt_q - 8'h01) begin
						p_st_q <= rac_pkg::P_CSUM;
					end
				end
				rac_pkg::P_CSUM: p_st_q <= rac_pkg::P_IDLE;
				default:         p_st_q <= rac_pkg::P_IDLE;
			endcase
		end
	end

	// ************************************************************
	// write staging
	// ************************************************************
	// values are held aside until the checksum proves the frame
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stage_q <= rac_pkg::SETTINGS_RST;
			hit_q   <= 4'h0;
			bad_q   <= 1'b0;
		end else if (rx_take && p_st_q == rac_pkg::P_CNT) begin
			hit_q <= 4'h0;
			bad_q <= 1'b0;
		end else if (rx_take && p_st_q == rac_pkg::P_DATA) begin
			// unknown position or value out of range spoils the frame
			if (wr_slot[2] && value_ok(wr_slot[1:0], host_rx_data)) begin
				stage_q[8*wr_slot[1:0] +: 8] <= host_rx_data;
				hit_q[wr_slot[1:0]]          <= 1'b1;
			end else begin
				bad_q <= 1'b1;
			end
		end
	end

	// ************************************************************
	// stored settings
	// ************************************************************
	for (genvar s = 0; s < 4; s++) begin : g_slot
		// each slot loads its staged byte on a clean write that staged it
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				settings[8*s +: 8] <= rac_pkg::SETTINGS_RST[8*s +: 8];
			end else if (commit && hit_q[s]) begin
				settings[8*s +: 8] <= stage_q[8*s +: 8];
			end
		end
	end

	// working copy: follows stored writes, runtime commands touch only it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			work_dest <= '{rac_pkg::RST_DEST_NETWORK_ID,
				rac_pkg::RST_DEST_NODE_ADDR_LOW};
		end else begin
			if (set_runtime_dest_network) begin
				work_dest.dest_network <= runtime_value;
			end else if (commit && hit_q[rac_pkg::SLOT_DNET]) begin
				work_dest.dest_network <= stage_q.dest_network_id;
			end
			if (set_runtime_dest_address) begin
				work_dest.dest_address <= runtime_value;
			end else if (commit && hit_q[rac_pkg::SLOT_DADR]) begin
				work_dest.dest_address <= stage_q.dest_node_address_low;
			end
		end
	end

	// ************************************************************
	// answer request
	// ************************************************************
	// frames with a bad checksum or read length get no answer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			resp_go_q <= 1'b0;
			resp_wr_q <= 1'b0;
			resp_st_q <= rac_pkg::STATUS_OK;
		end else begin
			resp_go_q <= 1'b0;
			if (rx_take && p_st_q == rac_pkg::P_CSUM &&
				host_rx_data == sum_q) begin
				resp_wr_q <= cmd_q == rac_pkg::CMD_WRITE;
				resp_st_q <= commit ? rac_pkg::STATUS_OK : rac_pkg::STATUS_FAIL;
				resp_go_q <= cmd_q == rac_pkg::CMD_WRITE ||
					lenf_q == rac_pkg::READ_LEN_FIELD;
			end
		end
	end

	// ************************************************************
	// answer sender
	// ************************************************************
	// byte presented in each sender state
	always_comb begin
		tx_byte = 8'h00;
		unique case (t_st_q)
			rac_pkg::T_STX: tx_byte = rac_pkg::START_BYTE;
			rac_pkg::T_CMD: tx_byte = resp_wr_q ?
				(rac_pkg::CMD_WRITE | rac_pkg::RESP_FLAG) :
				(rac_pkg::CMD_READ | rac_pkg::RESP_FLAG);
			rac_pkg::T_LEN: tx_byte = resp_wr_q ? rac_pkg::WRITE_RESP_LEN :
				8'(cnt_q + rac_pkg::LEN_EXTRA);
			rac_pkg::T_POS: tx_byte = resp_wr_q ? resp_st_q : pos_q;
			rac_pkg::T_CNT: tx_byte = cnt_q;
			// positions outside this store read as zero
			rac_pkg::T_DATA: tx_byte = rd_slot[2] ?
				settings[8*rd_slot[1:0] +: 8] : 8'h00;
			rac_pkg::T_CS:  tx_byte = tx_sum_q;
			default:        tx_byte = 8'h00;
		endcase
	end

	// load a byte, hold it until taken, then move on
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			t_st_q        <= rac_pkg::T_IDLE;
			host_tx_valid <= 1'b0;
			host_tx_data  <= 8'h00;
			tx_idx_q      <= 8'h00;
			tx_sum_q      <= 8'h00;
		end else if (t_st_q == rac_pkg::T_IDLE) begin
			tx_idx_q <= 8'h00;
			tx_sum_q <= 8'h00;
			if (resp_go_q) begin
				t_st_q <= rac_pkg::T_STX;
			end
		end else if (!host_tx_valid) begin
			host_tx_valid <= 1'b1;
			host_tx_data  <= tx_byte;
			tx_sum_q      <= tx_sum_q ^ tx_byte;
		end else if (host_tx_ready) begin
			host_tx_valid <= 1'b0;
			unique case (t_st_q)
				rac_pkg::T_STX: t_st_q <= rac_pkg::T_CMD;
				rac_pkg::T_CMD: t_st_q <= rac_pkg::T_LEN;
				rac_pkg::T_LEN: t_st_q <= rac_pkg::T_POS;
				rac_pkg::T_POS: t_st_q <= resp_wr_q ? rac_pkg::T_CS :
					rac_pkg::T_CNT;
				rac_pkg::T_CNT: t_st_q <= (cnt_q == 8'h00) ? rac_pkg::T_CS :
					rac_pkg::T_DATA;
				rac_pkg::T_DATA: begin
					tx_idx_q <= tx_idx_q + 8'h01;
					if (tx_idx_q == cnt_q - 8'h01) begin
						t_st_q <= rac_pkg::T_CS;
					end
				end
				rac_pkg::T_CS:  t_st_q <= rac_pkg::T_IDLE;
				default:        t_st_q <= rac_pkg::T_IDLE;
			endcase
		end
	end

	// ************************************************************
	// clear-channel retry
	// ************************************************************
	// check channel, on busy wait the stored delay in ms and check again
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			c_st_q   <= rac_pkg::C_IDLE;
			tries_q  <= 8'h00;
			delay_q  <= 8'h00;
			tick_q   <= '0;
			tx_go    <= 1'b0;
			tx_abort <= 1'b0;
		end else begin
			tx_go    <= 1'b0;
			tx_abort <= 1'b0;
			unique case (c_st_q)
				rac_pkg::C_IDLE: begin
					tries_q <= 8'h00;
					if (tx_req) begin
						c_st_q <= rac_pkg::C_CHECK;
					end
				end
				rac_pkg::C_CHECK: begin
					if (!chan_busy) begin
						tx_go  <= 1'b1;
						c_st_q <= rac_pkg::C_IDLE;
					end else if (tries_q >= cca_retry_limit) begin
						tx_abort <= 1'b1;
						c_st_q   <= rac_pkg::C_IDLE;
					end else begin
						tries_q <= tries_q + 8'h01;
						delay_q <= settings.cca_retry_delay;
						tick_q  <= ($bits(tick_q))'(MS_CYCLES - 1);
						c_st_q  <= rac_pkg::C_WAIT;
					end
				end
				rac_pkg::C_WAIT: begin
					if (tick_q != '0) begin
						tick_q <= tick_q - 1'b1;
					end else if (delay_q <= 8'h01) begin
						c_st_q <= rac_pkg::C_CHECK;
					end else begin
						delay_q <= delay_q - 8'h01;
						tick_q  <= ($bits(tick_q))'(MS_CYCLES - 1);
					end
				end
				default: c_st_q <= rac_pkg::C_IDLE;
			endcase
		end
	end

	// ************************************************************
	// address filter
	// ************************************************************
	rac_addr_filter u_filter (
		.clk                 (clk),
		.arst_n              (arst_n),
		.addressing_scheme   (addressing_scheme),
		.own_network_id      (settings.own_network_id),
		.own_node_address_low(own_node_address_low),
		.work_dest           (work_dest),
		.pkt_valid           (pkt_valid),
		.pkt_dest            (pkt_dest),
		.pkt_accept          (pkt_accept),
		.pkt_drop            (pkt_drop),
		.hdr_dest_network_en (hdr_dest_network_en),
		.hdr_dest_address_en (hdr_dest_address_en),
		.hdr_dest            (hdr_dest)
	);

endmodule

// [verilog/rac_pkg.sv]
// constants, types and carriers shared by the setting store
package rac_pkg;

	// ************************************************************
	// frame bytes
	// ************************************************************
	localparam logic [7:0] START_BYTE     = 8'h02; // opens every frame
	localparam logic [7:0] CMD_WRITE      = 8'h09; // store setting bytes
	localparam logic [7:0] CMD_READ       = 8'h0A; // fetch setting bytes
	localparam logic [7:0] RESP_FLAG      = 8'h40; // or-ed into answers
	localparam logic [7:0] STATUS_OK      = 8'h00; // write accepted
	localparam logic [7:0] STATUS_FAIL    = 8'h01; // write refused
	localparam logic [7:0] READ_LEN_FIELD = 8'h02; // length of a read
	localparam logic [7:0] WRITE_RESP_LEN = 8'h01; // length of write answer
	localparam logic [7:0] LEN_EXTRA      = 8'h02; // position plus count

	// ************************************************************
	// memory positions, defaults and limits
	// ************************************************************
	localparam logic [7:0] POS_CCA_RETRY_DELAY    = 8'h17;
	localparam logic [7:0] POS_DEST_NETWORK_ID    = 8'h18;
	localparam logic [7:0] POS_DEST_NODE_ADDR_LOW = 8'h19;
	localparam logic [7:0] POS_OWN_NETWORK_ID     = 8'h1C;
	localparam logic [7:0] RST_CCA_RETRY_DELAY    = 8'h14;
	localparam logic [7:0] RST_DEST_NETWORK_ID    = 8'h00;
	localparam logic [7:0] RST_DEST_NODE_ADDR_LOW = 8'h00;
	localparam logic [7:0] RST_OWN_NETWORK_ID     = 8'h00;
	localparam logic [7:0] CCA_RETRY_DELAY_MIN    = 8'h05;
	localparam logic [7:0] OWN_NETWORK_ID_MAX     = 8'hFE;
	localparam logic [7:0] BROADCAST              = 8'hFF;

	// slot index of each setting inside the packed store
	localparam logic [1:0] SLOT_CCA  = 2'h3;
	localparam logic [1:0] SLOT_DNET = 2'h2;
	localparam logic [1:0] SLOT_DADR = 2'h1;
	localparam logic [1:0] SLOT_ONET = 2'h0;

	// addressing schemes
	localparam logic [1:0] MODE_NONE = 2'h0;
	localparam logic [1:0] MODE_ONE  = 2'h1;
	localparam logic [1:0] MODE_TWO  = 2'h2;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 100;     // 10 MHz core clock
	localparam int MS_NS         = 1000000; // unit of the retry delay
	localparam int MS_CYCLES     = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ************************************************************
	// types
	// ************************************************************
	typedef struct packed {
		logic [7:0] cca_retry_delay;       // slot 3
		logic [7:0] dest_network_id;       // slot 2
		logic [7:0] dest_node_address_low; // slot 1
		logic [7:0] own_network_id;        // slot 0
	} rac_settings_t;

	typedef struct packed {
		logic [7:0] dest_network; // destination network identifier
		logic [7:0] dest_address; // destination node address
	} rac_addr_t;

	localparam rac_settings_t SETTINGS_RST = '{RST_CCA_RETRY_DELAY,
		RST_DEST_NETWORK_ID, RST_DEST_NODE_ADDR_LOW, RST_OWN_NETWORK_ID};

	typedef enum logic [2:0] {
		P_IDLE, P_CMD, P_LEN, P_POS, P_CNT, P_DATA, P_CSUM
	} rac_parse_t;

	typedef enum logic [2:0] {
		T_IDLE, T_STX, T_CMD, T_LEN, T_POS, T_CNT, T_DATA, T_CS
	} rac_tx_t;

	typedef enum logic [1:0] {
		C_IDLE, C_CHECK, C_WAIT
	} rac_cca_t;

endpackage

// [verilog/rac_addr_filter.sv]
// address filter for received packets and header fields for sent ones
module rac_addr_filter (
	input  wire logic              clk,
	input  wire logic              arst_n,
	input  wire logic [1:0]        addressing_scheme,
	input  wire logic [7:0]        own_network_id,
	input  wire logic [7:0]        own_node_address_low,
	input  wire rac_pkg::rac_addr_t work_dest,
	input  wire logic              pkt_valid,
	input  wire rac_pkg::rac_addr_t pkt_dest,
	output logic                   pkt_accept,
	output logic                   pkt_drop,
	output logic                   hdr_dest_network_en,
	output logic                   hdr_dest_address_en,
	output rac_pkg::rac_addr_t     hdr_dest
);

	// ************************************************************
	// receive decision
	// ************************************************************
	logic match; // packet is meant for this node

	// compare the packet destination against the node's own identity
	always_comb begin
		match = 1'b0;
		unique case (addressing_scheme)
			rac_pkg::MODE_ONE: match =
				(pkt_dest.dest_address == own_node_address_low) ||
				(pkt_dest.dest_address == rac_pkg::BROADCAST);
			rac_pkg::MODE_TWO: match =
				((pkt_dest.dest_network == own_network_id) &&
				(pkt_dest.dest_address == own_node_address_low)) ||
				((pkt_dest.dest_network == rac_pkg::BROADCAST) &&
				(pkt_dest.dest_address == rac_pkg::BROADCAST));
			default: match = 1'b1; // no addressing: every packet is taken
		endcase
	end

	// one-cycle verdict per offered packet
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pkt_accept <= 1'b0;
			pkt_drop   <= 1'b0;
		end else begin
			pkt_accept <= pkt_valid && match;
			pkt_drop   <= pkt_valid && !match;
		end
	end

	// ************************************************************
	// transmit header
	// ************************************************************
	// fields are carried only in the schemes that use them
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hdr_dest_network_en <= 1'b0;
			hdr_dest_address_en <= 1'b0;
			hdr_dest            <= '0;
		end else begin
			hdr_dest_network_en <= addressing_scheme == rac_pkg::MODE_TWO;
			hdr_dest_address_en <= addressing_scheme == rac_pkg::MODE_ONE ||
				addressing_scheme == rac_pkg::MODE_TWO;
			hdr_dest            <= work_dest;
		end
	end

endmodule

// [verification/rac_settings_store_props.sv]
// port assertions for the setting store
module rac_settings_store_props (
	input wire logic                   clk,
	input wire logic                   arst_n,
	input wire logic                   host_tx_valid,
	input wire logic [7:0]             host_tx_data,
	input wire logic                   host_tx_ready,
	input wire rac_pkg::rac_settings_t settings,
	input wire logic                   set_runtime_dest_network,
	input wire logic [7:0]             runtime_value,
	input wire rac_pkg::rac_addr_t     work_dest,
	input wire logic [1:0]             addressing_scheme,
	input wire logic                   pkt_valid,
	input wire rac_pkg::rac_addr_t     pkt_dest,
	input wire logic                   pkt_accept,
	input wire logic                   pkt_drop,
	input wire logic                   hdr_dest_network_en,
	input wire logic                   chan_busy,
	input wire logic                   tx_go
);
	// ************
	// checks on the single clock
	// ************
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	chk_tx_hold: assert property (host_tx_valid && !host_tx_ready
		|=> host_tx_valid && $stable(host_tx_data)) else $error("byte moved");
	chk_tx_bubble: assert property (host_tx_valid && host_tx_ready
		|=> !host_tx_valid) else $error("no gap after byte");
	chk_delay_floor: assert property (
		settings.cca_retry_delay >= 8'h05) else $error("delay below floor");
	chk_runtime_net: assert property (set_runtime_dest_network
		|=> work_dest.dest_network == $past(runtime_value)) else $error("net");
	chk_filter_one: assert property (pkt_valid && addressing_scheme ==
		2'h1 && pkt_dest.dest_address == 8'hFF |=> pkt_accept) else $error("b1");
	chk_filter_bcast: assert property (pkt_valid && addressing_scheme ==
		2'h2 && pkt_dest == 16'hFFFF |=> pkt_accept) else $error("b2");
	chk_filter_once: assert property (pkt_valid
		|=> pkt_accept != pkt_drop) else $error("no verdict");
	chk_net_header: assert property ($past(arst_n) |->
		hdr_dest_network_en == ($past(addressing_scheme) == 2'h2))
		else $error("header enable");
	chk_go_clear: assert property (tx_go
		|-> !$past(chan_busy)) else $error("sent on busy");
endmodule

bind rac_settings_store rac_settings_store_props i_props (.*);

// [verification/rac_host_model.sv]
// host controller model: sends command frames, takes answer bytes
module rac_host_model (
	input  wire logic       clk,
	input  wire logic       slow,
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	output logic            tx_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
	end
	// takes answers at once, or with random stalls when slow
	always @(posedge clk) begin
		#1 tx_ready = !slow || ($urandom_range(1) == 1);
	end
	// one frame, checksum appended, optionally spoiled
	task automatic send(input logic [7:0] f[$], input logic bad);
		logic [7:0] cs;
		cs = 8'h00;
		foreach (f[i]) cs ^= f[i];
		f.push_back(cs ^ {7'h00, bad});
		foreach (f[i]) begin
			@(posedge clk);
			#1 rx_data = f[i];
			rx_valid = 1'b1;
		end
		@(posedge clk);
		#1 rx_valid = 1'b0;
		rx_data = ~rx_data; // released line shows no stale byte
	endtask
endmodule

// [verification/rac_settings_store_tb.sv]
// self-checking bench of the setting store
module rac_settings_store_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int MS = 4; // shortened millisecond
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic slow = 1'b0;
	logic rx_v, tx_v, tx_r, go, abrt, acc, drop, p_v, t_req, busy, sn, sa;
	logic hn, ha;
	logic [7:0] rx_d, tx_d, rv, own_a, v;
	logic [1:0] mode;
	rac_pkg::rac_settings_t st, sv;
	rac_pkg::rac_addr_t wd, pd, hd;
	logic [7:0] exp_q[$];
	logic ev_q[$];
	logic [7:0] pos[4] = '{8'h17, 8'h18, 8'h19, 8'h1C};
	int n_fail = 0, n_tests = 0, cyc;
	always #50 clk = ~clk;
	rac_settings_store #(.MS_CYCLES(MS)) i_rac_settings_store (
		.clk(clk), .arst_n(arst_n), .host_rx_valid(rx_v),
		.host_rx_data(rx_d), .host_tx_valid(tx_v), .host_tx_data(tx_d),
		.host_tx_ready(tx_r), .settings(st), .set_runtime_dest_network(sn),
		.set_runtime_dest_address(sa), .runtime_value(rv), .work_dest(wd),
		.addressing_scheme(mode), .own_node_address_low(own_a),
		.pkt_valid(p_v), .pkt_dest(pd), .pkt_accept(acc), .pkt_drop(drop),
		.hdr_dest_network_en(hn), .hdr_dest_address_en(ha), .hdr_dest(hd),
		.tx_req(t_req), .chan_busy(busy), .cca_retry_limit(8'h01),
		.tx_go(go), .tx_abort(abrt));
	rac_host_model i_rac_host_model (.clk(clk), .slow(slow),
		.rx_valid(rx_v), .rx_data(rx_d), .tx_ready(tx_r));
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want) begin
			n_fail++;
			$display("Error %0t: got %h want %h", $time, seen, want);
		end
	endtask
	// note an answer with its checksum, send a frame, wait for the answer
	task automatic xfer(input logic [7:0] a[$], input logic [7:0] f[$]);
		logic [7:0] cs;
		cs = 8'h00;
		foreach (a[i]) cs ^= a[i];
		exp_q = {exp_q, a, cs};
		i_rac_host_model.send(f, 1'b0);
		for (cyc = 0; cyc < 200 && exp_q.size() != 0; cyc++) @(posedge clk);
		chk(exp_q.size(), 0);
		repeat (3) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] p, d, s);
		xfer('{8'h02, 8'h49, 8'h01, s}, '{8'h02, 8'h09, 8'h03, p, 8'h01, d});
	endtask
	task automatic rd(input logic [7:0] p, d);
		xfer('{8'h02, 8'h4A, 8'h03, p, 8'h01, d}, '{8'h02, 8'h0A, 8'h02, p, 8'h01});
	endtask
	// offer one received header under a scheme
	task automatic pkt(input logic [1:0] m, input logic [15:0] d, input logic e);
		mode = m;
		pd = d;
		p_v = 1'b1;
		ev_q.push_back(e);
		@(posedge clk);
		#1 p_v = 1'b0;
		@(posedge clk);
		#1 chk({hn, ha}, {m == 2'h2, m == 2'h1 || m == 2'h2});
	endtask
	// one transmit request against a busy or clear channel
	task automatic cca(input logic b);
		busy = b;
		ev_q.push_back(!b);
		t_req = 1'b1;
		@(posedge clk);
		#1 t_req = 1'b0;
		for (cyc = 0; !(go || abrt) && cyc < 300; cyc++) @(posedge clk) #1;
		@(posedge clk) #1;
	endtask
	// ************
	// outputs checked against the oldest note
	// ************
	always @(posedge clk) begin
		if (tx_v && tx_r) chk(tx_d, exp_q.pop_front());
		if (acc || drop) chk(acc, ev_q.pop_front());
		if (go || abrt) chk(go, ev_q.pop_front());
	end
	initial begin
		{p_v, t_req, busy, sn, sa, rv, mode, pd} = '0;
		own_a = 8'h21;
		void'($urandom(32'h8039));
		repeat (4) @(posedge clk);
		#1 arst_n = 1'b1;
		chk(st, rac_pkg::SETTINGS_RST);
		rd(8'h17, 8'h14);
		for (int i = 0; i < 4; i++) begin
			slow = i[0];
			v = 8'($urandom_range(254, i == 0 ? 5 : 0));
			wr(pos[i], v, 8'h00);
			rd(pos[i], v);
			chk(st[8*(3-i) +: 8], v);
		end
		sv = st;
		wr(8'h17, 8'h04, 8'h01);
		wr(8'h1C, 8'hFF, 8'h01);
		i_rac_host_model.send('{8'h02, 8'h09, 8'h03, 8'h18, 8'h01,
			8'h55}, 1'b1);
		// a read with a wrong length field must stay unanswered
		i_rac_host_model.send('{8'h02, 8'h0A, 8'h03, 8'h17,
			8'h01}, 1'b0);
		repeat (10) @(posedge clk);
		#1 chk(st, sv);
		{sn, rv} = {1'b1, 8'hA5};
		@(posedge clk);
		#1 {sn, sa, rv} = {2'b01, 8'h3C};
		@(posedge clk);
		#1 sa = 1'b0;
		@(posedge clk);
		#1 chk(wd, 16'hA53C);
		chk(st, sv);
		pkt(2'h1, 16'h0021, 1'b1);
		pkt(2'h1, 16'h00FF, 1'b1);
		pkt(2'h1, 16'h0022, 1'b0);
		pkt(2'h2, {sv[7:0], 8'h21}, 1'b1);
		pkt(2'h2, {~sv[7:0], 8'h21}, 1'b0);
		pkt(2'h2, 16'hFFFF, 1'b1);
		pkt(2'h0, 16'h1234, 1'b1);
		pkt(2'h3, 16'h1234, 1'b1);
		chk(hd, 16'hA53C);
		wr(8'h17, 8'h05, 8'h00);
		cca(1'b1);
		chk(cyc >= 5 * MS, 1'b1);
		chk(cyc <= 5 * MS + 3, 1'b1);
		cca(1'b0);
		chk(cyc <= 3, 1'b1);
		final_report();
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		final_report();
	end
	task automatic final_report();
		if (n_fail == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
endmodule
